// File: ssc_params.svh
`ifndef SSC_PARAMS_SVH
`define SSC_PARAMS_SVH

// ---------------------------------------------
// register byte offsets
// ---------------------------------------------
`define A_CTRL   8'h00
`define A_TXMODE 8'h04
`define A_RHR    8'h20
`define A_THR    8'h24
`define A_RSHR   8'h30
`define A_TSHR   8'h34
`define A_CMP0   8'h38
`define A_CMP1   8'h3C
`define A_SR     8'h40
`define A_MASK   8'h4C
`define A_TCNT   8'h50
`define A_TNXT   8'h54
`define A_RCNT   8'h58
`define A_RNXT   8'h5C

// ---------------------------------------------
// transmit mode fields
// ---------------------------------------------
`define TM_WLEN  4:0
`define TM_DEF   5
`define TM_SLEN  19:16
`define TM_SOS   22:20
`define TM_SDEN  23
`define TM_EDGE  24
`define TM_SLEXT 31:28

// ---------------------------------------------
// sync output select codes
// ---------------------------------------------
`define SOS_NONE 3'h0
`define SOS_NEG  3'h1
`define SOS_POS  3'h2
`define SOS_LOW  3'h3
`define SOS_HIGH 3'h4
`define SOS_TGL  3'h5

// ---------------------------------------------
// reset values
// ---------------------------------------------
`define RST_WORD 32'h0000_0000
`define RST_HALF 16'h0000

`endif

// File: ssc_pkg.sv
package ssc_pkg;

  typedef enum logic [1:0]
  {
    TX_IDLE = 2'b00,
    TX_SYNC = 2'b01,
    TX_DATA = 2'b10
  } tx_state_t;

  typedef struct packed {
    logic        tx_en;
    logic        rx_en;
    logic [31:0] txmode;
    logic [15:0] tsh;
    logic [15:0] cmp0;
    logic [15:0] cmp1;
    logic [11:0] mask;
    logic [31:0] thr;
    logic        thr_full;
    logic [31:0] tx_shift_reg;
    tx_state_t   tx_st;
    logic [7:0]  tx_cnt;
    logic        tx_out;
    logic        frame;
    logic        tgl;
    logic [31:0] rhr;
    logic [15:0] rsh;
    logic [31:0] rx_sh;
    logic [4:0]  rx_cnt;
    logic        in_sync;
    logic        in_data;
    logic        rx_ready_flag;
    logic        ovr;
    logic        cp0f;
    logic        cp1f;
    logic        tx_sync_seen;
    logic        rx_sync_seen;
    logic        tx_count_done;
    logic        rx_count_done;
    logic        irq;
    logic [31:0] rdata;
  } core_t;

  typedef struct packed {
    logic [15:0] cnt;
    logic [15:0] nxt;
    logic        hit;
  } dma_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } sync_t;

endpackage : ssc_pkg

// File: pin_sync.sv
`timescale 1ns/1ns
module pin_sync
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // pin and synchronised view
  input  wire logic d_i,
  output logic      q_o,
  output logic      rise_o,
  output logic      fall_o
);
  import ssc_pkg::*;

  sync_t r;
  sync_t n;

  always_comb
  begin
    n    = r;
    n.s1 = d_i;
    n.s2 = r.s1;
    n.s3 = r.s2;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      r <= '0;
    else
      r <= n;
  end

  assign q_o    = r.s2;
  assign rise_o = r.s2 & ~r.s3;
  assign fall_o = ~r.s2 & r.s3;

endmodule : pin_sync

// File: dma_count.sv
`timescale 1ns/1ns
module dma_count
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // software writes
  input  wire logic        wr_cnt_i,
  input  wire logic        wr_next_i,
  input  wire logic [15:0] wdata_i,
  // one word moved
  input  wire logic        dec_i,
  // counters
  output logic [15:0]      count_o,
  output logic [15:0]      next_o,
  output logic             hit_o
);
  import ssc_pkg::*;

  dma_t r;
  dma_t n;

  always_comb
  begin
    n     = r;
    n.hit = 1'b0;
    if (dec_i && r.cnt != 16'h0000)
    begin
      n.cnt = r.cnt - 16'h0001;
      n.hit = (r.cnt == 16'h0001);
    end
    else if (r.cnt == 16'h0000 && r.nxt != 16'h0000)
    begin
      n.cnt = r.nxt;
      n.nxt = 16'h0000;
    end
    if (wr_cnt_i)
      n.cnt = wdata_i;
    if (wr_next_i)
      n.nxt = wdata_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      r <= '0;
    else
      r <= n;
  end

  assign count_o = r.cnt;
  assign next_o  = r.nxt;
  assign hit_o   = r.hit;

endmodule : dma_count

// File: ssc_tx_sync.sv
//
// Overview of operation
// RL1: frame sync pulse lasts length plus one tx clocks; sync data shifts that many bits (code sends at most 16 sync bits, then default level)
// RL2: sync length is the length field joined with its extension field
// RL3: select 0 drives no frame sync; 1 negative pulse, 2 positive pulse
// RL4: select 3 holds frame low during data, 4 holds it high
// RL5: select 5 toggles frame at each transfer start; 6-7 reserved
// RL6: during sync, serial out is default level or sync holding bits
// RL7: tx sync flag on rising frame edge for select 0, falling for 1
// RL8: rx and tx holding words are right aligned whatever the word length
// RL9: rx sync holding register holds 16 bits caught during rx frame sync
// RL10: tx sync holding register holds 16 bits sent during tx frame sync
// RL11: compare-zero flag set on match with compare zero, cleared by status read
// RL12: compare-one flag set on match with compare one, cleared by status read
// RL13: tx ready is 1 while tx holding is empty, else 0
// RL14: tx drained only when last word was moved and fully sent
// RL15: tx count done set at counter zero, cleared on tx counter writes
// RL16: buffer flags show both tx or both rx counters at zero
// RL17: rx ready set when a word is loaded, 0 when holding empty
// RL18: overrun when a word lands before previous was read; status read clears
// RL19: rx count done set at counter zero, cleared on rx counter writes
// RL20: tx sync flag holds until status read, which clears it
// RL21: rx sync flag set on rx frame sync, cleared by status read
// RL22: each word carries word length plus one bits; zero is forbidden
// RL23: interrupt high while any flag is set with its mask bit on
//
// Implementation choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ns
`include "ssc_params.svh"
module ssc_tx_sync
(
  // clock and reset
  input  wire logic        MCLK_I,
  input  wire logic        SRST_I,
  // register port
  input  wire logic [7:0]  ADDR_I,
  input  wire logic [31:0] WDATA_I,
  input  wire logic        WR_I,
  input  wire logic        RD_I,
  output logic [31:0]      RDATA_O,
  // transmit pins
  input  wire logic        TX_CLK_I,
  output logic             SERIAL_OUT_O,
  output logic             TX_FRAME_O,
  output logic             TX_FRAME_OE_O,
  // receive pins
  input  wire logic        RX_CLK_I,
  input  wire logic        RX_FRAME_I,
  input  wire logic        RX_DATA_I,
  // interrupt
  output logic             INT_O
);
  import ssc_pkg::*;

  // ---------------------------------------------
  // state and pin views
  // ---------------------------------------------
  core_t       r;
  core_t       n;
  logic        tclk_fall;
  logic        rclk_rise;
  logic        rfrm;
  logic        rfrm_rise;
  logic        rx_word;
  logic [15:0] tcnt;
  logic [15:0] tnxt;
  logic [15:0] rcnt;
  logic [15:0] rnxt;
  logic        thit;
  logic        rhit;
  logic        wr_thr;
  logic        rd_rhr;

  pin_sync u_tclk
  (
    .clk_i  (MCLK_I),
    .rst_i  (SRST_I),
    .d_i    (TX_CLK_I),
    .q_o    (),
    .rise_o (),
    .fall_o (tclk_fall)
  );

  pin_sync u_rclk
  (
    .clk_i  (MCLK_I),
    .rst_i  (SRST_I),
    .d_i    (RX_CLK_I),
    .q_o    (),
    .rise_o (rclk_rise),
    .fall_o ()
  );

  pin_sync u_rfrm
  (
    .clk_i  (MCLK_I),
    .rst_i  (SRST_I),
    .d_i    (RX_FRAME_I),
    .q_o    (rfrm),
    .rise_o (rfrm_rise),
    .fall_o ()
  );

  pin_sync u_rx_word
  (
    .clk_i  (MCLK_I),
    .rst_i  (SRST_I),
    .d_i    (RX_DATA_I),
    .q_o    (rx_word),
    .rise_o (),
    .fall_o ()
  );

  // ---------------------------------------------
  // transfer counters
  // ---------------------------------------------
  assign wr_thr = WR_I && ADDR_I == `A_THR;
  assign rd_rhr = RD_I && ADDR_I == `A_RHR && r.rx_ready_flag;

  dma_count u_txcnt
  (
    .clk_i     (MCLK_I),
    .rst_i     (SRST_I),
    .wr_cnt_i  (WR_I && ADDR_I == `A_TCNT),
    .wr_next_i (WR_I && ADDR_I == `A_TNXT),
    .wdata_i   (WDATA_I[15:0]),
    .dec_i     (wr_thr),
    .count_o   (tcnt),
    .next_o    (tnxt),
    .hit_o     (thit)
  );

  dma_count u_rxcnt
  (
    .clk_i     (MCLK_I),
    .rst_i     (SRST_I),
    .wr_cnt_i  (WR_I && ADDR_I == `A_RCNT),
    .wr_next_i (WR_I && ADDR_I == `A_RNXT),
    .wdata_i   (WDATA_I[15:0]),
    .dec_i     (rd_rhr),
    .count_o   (rcnt),
    .next_o    (rnxt),
    .hit_o     (rhit)
  );

  // ---------------------------------------------
  // helpers
  // ---------------------------------------------
  function automatic logic frame_of(input tx_state_t st, input logic [2:0] sos, input logic tg);
    logic f;
    f = 1'b0;
    case (sos)
      `SOS_NEG:  f = (st != TX_SYNC);          // [RL3]
      `SOS_POS:  f = (st == TX_SYNC);          // [RL3]
      `SOS_LOW:  f = (st != TX_DATA);          // [RL4]
      `SOS_HIGH: f = (st == TX_DATA);          // [RL4]
      `SOS_TGL:  f = tg;                       // [RL5]
      default:   f = 1'b0;
    endcase
    return f;
  endfunction : frame_of

  function automatic logic [31:0] status_of(input core_t c, input logic [15:0] tc, input logic [15:0] tn,
                                            input logic [15:0] rc, input logic [15:0] rn);
    logic [31:0] s;
    s     = `RST_WORD;
    s[0]  = ~c.thr_full;                                   // [RL13]
    s[1]  = ~c.thr_full && c.tx_st == TX_IDLE;             // [RL14]
    s[2]  = c.tx_count_done;
    s[3]  = (tc == 16'h0000) && (tn == 16'h0000);          // [RL16]
    s[4]  = c.rx_ready_flag;                                       // [RL17]
    s[5]  = c.ovr;
    s[6]  = c.rx_count_done;
    s[7]  = (rc == 16'h0000) && (rn == 16'h0000);          // [RL16]
    s[8]  = c.cp0f;
    s[9]  = c.cp1f;
    s[10] = c.tx_sync_seen;
    s[11] = c.rx_sync_seen;
    s[16] = c.tx_en;
    s[17] = c.rx_en;
    return s;
  endfunction : status_of

  // ---------------------------------------------
  // next state
  // ---------------------------------------------
  always_comb
  begin
    logic [4:0]  wlen;
    logic [7:0]  slen;
    logic [2:0]  sos;
    logic        def;
    logic        sden;
    logic [4:0]  idx;
    logic [4:0]  rc;
    logic [31:0] word;
    logic [31:0] stat;
    wlen = r.txmode[`TM_WLEN];
    slen = {r.txmode[`TM_SLEXT], r.txmode[`TM_SLEN]};   // [RL2]
    sos  = r.txmode[`TM_SOS];
    def  = r.txmode[`TM_DEF];
    sden = r.txmode[`TM_SDEN];
    idx  = 5'h00;
    rc   = 5'h00;
    word = `RST_WORD;
    stat = status_of(r, tcnt, tnxt, rcnt, rnxt);
    n    = r;

    // read and its side effects
    n.rdata = `RST_WORD;
    if (RD_I)
    begin
      case (ADDR_I)
        `A_CTRL:   n.rdata = {30'h0000_0000, r.rx_en, r.tx_en};
        `A_TXMODE: n.rdata = r.txmode;
        `A_RHR:
        begin
          n.rdata = r.rhr;                              // [RL8]
          n.rx_ready_flag = 1'b0;                               // [RL17]
        end
        `A_RSHR:   n.rdata = {16'h0000, r.rsh};         // [RL9]
        `A_TSHR:   n.rdata = {16'h0000, r.tsh};         // [RL10]
        `A_CMP0:   n.rdata = {16'h0000, r.cmp0};
        `A_CMP1:   n.rdata = {16'h0000, r.cmp1};
        `A_MASK:   n.rdata = {20'h00000, r.mask};
        `A_TCNT:   n.rdata = {16'h0000, tcnt};
        `A_TNXT:   n.rdata = {16'h0000, tnxt};
        `A_RCNT:   n.rdata = {16'h0000, rcnt};
        `A_RNXT:   n.rdata = {16'h0000, rnxt};
        `A_SR:
        begin
          n.rdata = stat;
          n.cp0f  = 1'b0;                               // [RL11]
          n.cp1f  = 1'b0;                               // [RL12]
          n.ovr   = 1'b0;                               // [RL18]
          n.tx_sync_seen = 1'b0;                               // [RL20]
          n.rx_sync_seen = 1'b0;                               // [RL21]
        end
        default:   n.rdata = `RST_WORD;
      endcase
    end

    // transmitter
    case (r.tx_st)
      TX_IDLE:
      begin
        n.tx_out = def;
        if (r.tx_en && r.thr_full && tclk_fall)
        begin
          n.tx_shift_reg      = r.thr;
          n.thr_full = 1'b0;                            // [RL13]
          n.tx_cnt   = 8'h00;
          n.tgl      = ~r.tgl;                          // [RL5]
          if (sos != `SOS_NONE)
          begin
            n.tx_st  = TX_SYNC;
            n.tx_out = sden ? r.tsh[0] : def;           // [RL6]
          end
          else
          begin
            n.tx_st  = TX_DATA;
            n.tx_out = r.thr[wlen];                     // [RL8]
          end
        end
      end
      TX_SYNC:
      begin
        if (tclk_fall)
        begin
          if (r.tx_cnt == slen)                         // [RL1]
          begin
            n.tx_st  = TX_DATA;
            n.tx_cnt = 8'h00;
            n.tx_out = r.tx_shift_reg[wlen];
          end
          else
          begin
            n.tx_cnt = r.tx_cnt + 8'h01;
            n.tx_out = def;                             // [RL6]
            if (sden && n.tx_cnt < 8'h10)
              n.tx_out = r.tsh[n.tx_cnt[3:0]];          // [RL1] [RL10]
          end
        end
      end
      TX_DATA:
      begin
        if (tclk_fall)
        begin
          if (r.tx_cnt[4:0] == wlen)                    // [RL22]
          begin
            n.tx_st  = TX_IDLE;
            n.tx_out = def;                             // [RL14]
          end
          else
          begin
            n.tx_cnt = r.tx_cnt + 8'h01;
            idx      = wlen - n.tx_cnt[4:0];
            n.tx_out = r.tx_shift_reg[idx];
          end
        end
      end
      default:
      begin
        n.tx_st = TX_IDLE;
      end
    endcase
    n.frame = frame_of(n.tx_st, sos, n.tgl);

    // tx frame edge flag, set wins over read clear
    if (sos != `SOS_NONE && n.frame != r.frame)
    begin
      if (r.txmode[`TM_EDGE] ? r.frame : n.frame)       // [RL7]
        n.tx_sync_seen = 1'b1;                                 // [RL20]
    end

    // software writes
    if (WR_I)
    begin
      case (ADDR_I)
        `A_CTRL:
        begin
          n.tx_en = WDATA_I[0];
          n.rx_en = WDATA_I[1];
        end
        `A_TXMODE: n.txmode = WDATA_I;
        `A_THR:
        begin
          n.thr      = WDATA_I;                         // [RL8]
          n.thr_full = 1'b1;                            // [RL13]
        end
        `A_TSHR:   n.tsh  = WDATA_I[15:0];              // [RL10]
        `A_CMP0:   n.cmp0 = WDATA_I[15:0];
        `A_CMP1:   n.cmp1 = WDATA_I[15:0];
        `A_MASK:   n.mask = WDATA_I[11:0];
        `A_TCNT:   n.tx_count_done = 1'b0;                      // [RL15]
        `A_TNXT:   n.tx_count_done = 1'b0;                      // [RL15]
        `A_RCNT:   n.rx_count_done = 1'b0;                      // [RL19]
        `A_RNXT:   n.rx_count_done = 1'b0;                      // [RL19]
        default:   n.tx_en = r.tx_en;
      endcase
    end
    if (thit)
      n.tx_count_done = 1'b1;                                   // [RL15]
    if (rhit)
      n.rx_count_done = 1'b1;                                   // [RL19]

    // receiver
    if (r.rx_en && rfrm_rise)
      n.rx_sync_seen = 1'b1;                                   // [RL21]
    if (r.rx_en && rclk_rise)
    begin
      if (rfrm)
      begin
        n.rsh     = {r.rsh[14:0], rx_word};                // [RL9]
        n.in_sync = 1'b1;
        n.in_data = 1'b0;
      end
      else if (r.in_sync || r.in_data)
      begin
        rc        = r.in_sync ? 5'h00 : r.rx_cnt;
        word      = r.in_sync ? {31'h0000_0000, rx_word} : {r.rx_sh[30:0], rx_word};
        n.in_sync = 1'b0;
        n.in_data = 1'b1;
        n.rx_sh   = word;
        n.rx_cnt  = rc + 5'h01;
        if (rc == wlen)                                 // [RL22]
        begin
          n.in_data = 1'b0;
          n.rx_cnt  = 5'h00;
          n.rhr     = word;                             // [RL8]
          n.rx_ready_flag   = 1'b1;                             // [RL17]
          if (r.rx_ready_flag && !rd_rhr)
            n.ovr = 1'b1;                               // [RL18]
          if (word[15:0] == r.cmp0)
            n.cp0f = 1'b1;                              // [RL11]
          if (word[15:0] == r.cmp1)
            n.cp1f = 1'b1;                              // [RL12]
        end
      end
    end

    n.irq = |(stat[11:0] & r.mask);                     // [RL23]
  end

  // ---------------------------------------------
  // state register
  // ---------------------------------------------
  always_ff @(posedge MCLK_I)
  begin
    if (SRST_I)
    begin
      r       <= '0;
      r.tx_st <= TX_IDLE;
    end
    else
      r <= n;
  end

  // ---------------------------------------------
  // outputs
  // ---------------------------------------------
  assign RDATA_O       = r.rdata;
  assign SERIAL_OUT_O  = r.tx_out;
  assign TX_FRAME_O    = r.frame;
  assign TX_FRAME_OE_O = r.txmode[`TM_SOS] != `SOS_NONE;   // [RL3]
  assign INT_O         = r.irq;

endmodule : ssc_tx_sync

// File: ssc_tx_sync_monitor.sv
`timescale 1ns/1ns
`include "ssc_params.svh"
module ssc_tx_sync_monitor
(
  // clock and reset
  input wire logic        MCLK_I,
  input wire logic        SRST_I,
  // register port
  input wire logic [7:0]  ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic        WR_I,
  input wire logic        RD_I,
  input wire logic [31:0] RDATA_O,
  // pins
  input wire logic        TX_CLK_I,
  input wire logic        TX_FRAME_O,
  input wire logic        TX_FRAME_OE_O,
  input wire logic        INT_O
);
  logic [2:0]  sos_r;
  logic [1:0]  age_r;
  logic [3:0]  fall_r;
  logic        clk_d_r;
  logic        tx_enabled_r;
  logic [11:0] mask_r;
  logic [15:0] tsh_r;
  logic [15:0] cp0_r;
  logic [15:0] cp1_r;

  // ---------------------------------------------
  // shadow registers
  // ---------------------------------------------
  always_ff @(posedge MCLK_I)
  begin
    if (SRST_I)
    begin
      {sos_r, age_r, fall_r, clk_d_r, tx_enabled_r} <= '0;
      {mask_r, tsh_r, cp0_r, cp1_r}           <= '0;
    end
    else
    begin
      clk_d_r <= TX_CLK_I;
      fall_r  <= (clk_d_r && !TX_CLK_I) ? 4'h1 : fall_r + {3'h0, fall_r != 4'hF};
      age_r   <= (WR_I && ADDR_I == `A_TXMODE) ? 2'h0 : age_r + {1'h0, age_r != 2'h3};
      if (WR_I && ADDR_I == `A_TXMODE) sos_r <= WDATA_I[`TM_SOS];
      if (WR_I && ADDR_I == `A_CTRL) tx_enabled_r <= WDATA_I[0];
      if (WR_I && ADDR_I == `A_MASK) mask_r <= WDATA_I[11:0];
      if (WR_I && ADDR_I == `A_TSHR) tsh_r <= WDATA_I[15:0];
      if (WR_I && ADDR_I == `A_CMP0) cp0_r <= WDATA_I[15:0];
      if (WR_I && ADDR_I == `A_CMP1) cp1_r <= WDATA_I[15:0];
    end
  end

  // ---------------------------------------------
  // properties
  // ---------------------------------------------
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (SRST_I);

  sequence sr_rd;
    RD_I && ADDR_I == `A_SR;
  endsequence

  a_tsh_readback: assert property (RD_I && ADDR_I == `A_TSHR |=> RDATA_O == {16'h0000, tsh_r})
    else $error("sync holding readback wrong");
  a_cmp0_readback: assert property (RD_I && ADDR_I == `A_CMP0 |=> RDATA_O == {16'h0000, cp0_r})
    else $error("compare zero readback wrong");
  a_cmp1_readback: assert property (RD_I && ADDR_I == `A_CMP1 |=> RDATA_O == {16'h0000, cp1_r})
    else $error("compare one readback wrong");
  a_rsh_upper_zero: assert property (RD_I && ADDR_I == `A_RSHR |=> RDATA_O[31:16] == 16'h0000)
    else $error("rx sync holding upper bits set");
  a_oe_follows_select: assert property (age_r == 2'h3 |-> TX_FRAME_OE_O == (sos_r != 3'h0))
    else $error("frame enable does not match select");
  a_frame_link_edge: assert property ($changed(TX_FRAME_O) && age_r == 2'h3 |-> fall_r inside {[1:6]})
    else $error("frame moved away from link falling edge");
  a_flags_read_clear: assert property (sr_rd ##2 sr_rd |=> RDATA_O[9:8] == 2'b00 && !RDATA_O[5])
    else $error("sticky flags survived status read");
  a_int_masked_off: assert property (mask_r == 12'h000 && $past(mask_r) == 12'h000 |-> !INT_O)
    else $error("interrupt high while fully masked");
  a_tx_ready_flag_after_write: assert property (!tx_enabled_r && WR_I && ADDR_I == `A_THR ##2 sr_rd |=> !RDATA_O[0])
    else $error("tx ready high with word waiting");

  c_status_read: cover property (sr_rd);
  c_tx_write: cover property (WR_I && ADDR_I == `A_THR);
  c_int_rise: cover property ($rose(INT_O));
endmodule : ssc_tx_sync_monitor

bind ssc_tx_sync ssc_tx_sync_monitor i_ssc_tx_sync_monitor (.MCLK_I, .SRST_I, .ADDR_I, .WDATA_I, .WR_I, .RD_I,
  .RDATA_O, .TX_CLK_I, .TX_FRAME_O, .TX_FRAME_OE_O, .INT_O);

// File: ssc_partner.sv
`timescale 1ns/1ns
module ssc_partner
(
  // link clocks and receive lines
  output logic      tx_clk_o,
  output logic      rx_clk_o,
  output logic      rx_frame_o,
  output logic      rx_data_o,
  // transmit lines from the block
  input  wire logic serial_i,
  input  wire logic frame_i
);
  logic       tx_run;
  logic [1:0] smp_q[$];

  // ---------------------------------------------
  // tx clock, sampled just before each fall
  // ---------------------------------------------
  initial
  begin
    {tx_clk_o, rx_clk_o, rx_frame_o, rx_data_o, tx_run} = '0;
    #1;
    forever
    begin
      #16;
      if (tx_run) tx_clk_o = 1'b1;
      #16;
      if (tx_clk_o) smp_q.push_back({frame_i, serial_i});
      tx_clk_o = 1'b0;
    end
  end

  // ---------------------------------------------
  // one rx frame: 16 sync bits, 8 data bits
  // ---------------------------------------------
  task automatic send_word(input logic [15:0] sync, input logic [7:0] word);
    #1;
    for (int k = 0; k < 24; k++)
    begin
      rx_frame_o = (k < 16);
      rx_data_o  = (k < 16) ? sync[15 - k] : word[23 - k];
      #16 rx_clk_o = 1'b1;
      #16 rx_clk_o = 1'b0;
    end
    rx_frame_o = 1'b0;
    rx_data_o  = ~rx_data_o;
  endtask : send_word
endmodule : ssc_partner

// File: tb.sv
`timescale 1ns/1ns
`include "ssc_params.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb;
  import ssc_pkg::*;
  logic        MCLK_I, SRST_I, WR_I, RD_I;
  logic [7:0]  ADDR_I;
  logic [31:0] WDATA_I, RDATA_O, d;
  logic        SERIAL_OUT_O, TX_FRAME_O, TX_FRAME_OE_O, INT_O;
  logic        TX_CLK_I, RX_CLK_I, RX_FRAME_I, RX_DATA_I;
  logic [15:0] tsh, sy;
  logic [7:0]  w, w2;
  logic        act, sden, f0, seen;
  int          bad_count, cmp_count, cyc, i0, n;

  ssc_tx_sync i_ssc_tx_sync (.MCLK_I, .SRST_I, .ADDR_I, .WDATA_I, .WR_I, .RD_I, .RDATA_O, .TX_CLK_I,
    .SERIAL_OUT_O, .TX_FRAME_O, .TX_FRAME_OE_O, .RX_CLK_I, .RX_FRAME_I, .RX_DATA_I, .INT_O);
  ssc_partner i_ssc_partner (.tx_clk_o(TX_CLK_I), .rx_clk_o(RX_CLK_I), .rx_frame_o(RX_FRAME_I),
    .rx_data_o(RX_DATA_I), .serial_i(SERIAL_OUT_O), .frame_i(TX_FRAME_O));

  // ---------------------------------------------
  // clock, bus tasks, expectations
  // ---------------------------------------------
  initial
  begin
    MCLK_I = 1'b0;
    forever #2 MCLK_I = ~MCLK_I;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge MCLK_I);
    WR_I    <= 1'b1;
    ADDR_I  <= a;
    WDATA_I <= v;
    @(posedge MCLK_I);
    WR_I    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge MCLK_I);
    RD_I   <= 1'b1;
    ADDR_I <= a;
    @(posedge MCLK_I);
    RD_I   <= 1'b0;
    #1 v = RDATA_O;
  endtask : rd

  function automatic logic [1:0] exp_smp(input int k, input logic a, input logic [15:0] t,
                                         input logic den, input logic [7:0] v);
    if (k < 18)
      return {a, (den && k < 16) ? t[k] : ~den};
    return {~a, v[25 - k]};
  endfunction : exp_smp

  task automatic tally_and_finish;
    $display("comparisons=%0d mismatches=%0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish

  always @(posedge MCLK_I)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      bad_count++;
      tally_and_finish();
    end
  end

  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  initial
  begin
    {SRST_I, WR_I, RD_I, ADDR_I, WDATA_I} = {1'b1, 42'h0};
    {bad_count, cmp_count, cyc} = '0;
    void'($urandom(32'hD582D2ED));
    repeat (20) @(posedge MCLK_I);
    SRST_I <= 1'b0;
    rd(`A_CMP0, d); `CHK(d, 32'h0000_0000)
    rd(8'h10, d); `CHK(d, 32'h0000_0000)
    rd(`A_SR, d); `CHK({d[7], d[3], d[0]}, 3'b111)
    wr(`A_TCNT, 32'h0000_0001);
    rd(`A_SR, d); `CHK({d[3], d[2]}, 2'b00)
    i_ssc_partner.tx_run = 1'b1;
    for (int s = 0; s < 6; s++)
    begin
      tsh  = 16'($urandom());
      w    = 8'($urandom());
      sden = s[0];
      act  = (s == 2);
      wr(`A_CTRL, 32'h0000_0000);
      wr(`A_TXMODE, {4'h1, 3'h0, s[1], sden, s[2:0], 4'h1, 10'h0, ~sden, 5'h07});
      wr(`A_TSHR, {16'hFFFF, tsh});
      rd(`A_TSHR, d); `CHK(d, {16'h0000, tsh})
      wr(`A_THR, {24'hABCDEF, w});
      rd(`A_SR, d); `CHK(d[0], 1'b0)
      if (s == 1)
      begin
        rd(`A_SR, d); `CHK({d[3], d[2]}, 2'b11)
      end
      f0 = TX_FRAME_O;
      wr(`A_CTRL, 32'h0000_0001);
      i_ssc_partner.smp_q.delete();
      {n, d, seen} = '0;
      while (!d[1] && n < 400)
      begin
        rd(`A_SR, d);
        seen |= d[10];
        n++;
      end
      `CHK(d[1:0], 2'b11)
      if (s == 0)
        `CHK({TX_FRAME_OE_O, TX_FRAME_O, seen}, 3'b000)
      else if (s < 3)
      begin
        `CHK(seen, 1'b1)
        `CHK(TX_FRAME_OE_O, 1'b1)
        i0 = 0;
        while (i0 < 60 && i_ssc_partner.smp_q[i0][1] !== act) i0++;
        for (int k = 0; k < 26; k++)
          `CHK(i_ssc_partner.smp_q[i0 + k], exp_smp(k, act, tsh, sden, w))
      end
      else if (s < 5)
      begin
        n = 0;
        foreach (i_ssc_partner.smp_q[j]) n += (i_ssc_partner.smp_q[j][1] === (s == 4));
        `CHK(n, 8)
      end
      else
        `CHK(TX_FRAME_O, ~f0)
    end
    wr(`A_TNXT, 32'h0000_0005);
    rd(`A_SR, d); `CHK({d[3], d[2]}, 2'b00)
    // receive side: compare hits, overrun, sync capture
    sy = 16'($urandom());
    w  = 8'($urandom());
    w2 = ~w;
    wr(`A_CTRL, 32'h0000_0002);
    wr(`A_RCNT, 32'h0000_0001);
    wr(`A_CMP0, {24'h0, w});
    wr(`A_CMP1, {24'h0, w2});
    wr(`A_MASK, 32'h0000_0010);
    i_ssc_partner.send_word(sy, w);
    for (n = 0; INT_O !== 1'b1 && n < 60; n++) @(posedge MCLK_I);
    `CHK(INT_O, 1'b1)
    rd(`A_SR, d); `CHK({d[11], d[9], d[8], d[5], d[4]}, 5'b10101)
    rd(`A_SR, d); `CHK({d[11], d[9], d[8], d[5]}, 4'b0000)
    wr(`A_MASK, 32'h0000_0000);
    rd(`A_CMP1, d); `CHK(INT_O, 1'b0)
    wr(`A_MASK, 32'h0000_0020);
    i_ssc_partner.send_word(~sy, w2);
    for (n = 0; INT_O !== 1'b1 && n < 60; n++) @(posedge MCLK_I);
    rd(`A_SR, d); `CHK({d[9], d[8], d[5], d[4]}, 4'b1011)
    rd(`A_RHR, d); `CHK(d, {24'h0, w2})
    rd(`A_RSHR, d); `CHK(d, {16'h0000, ~sy})
    rd(`A_SR, d); `CHK({d[7], d[6], d[5], d[4]}, 4'b1100)
    tally_and_finish();
  end
endmodule : tb
